//--- design/usep_top.v
// User sense and enable pin block with APB register access and interrupt
//
// Functional notes
// - Reset clears every internal register
// - Reset clears mode bit zero: stop
// - Sense 0 held 160 ns sets bit
// - Sense 1 held 160 ns sets bit
// - Sense bits sticky until bus clears
// - Enable output 0 follows drive bit
// - Enable output 1 follows drive bit
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "usep_regs.vh"

module usep_top #(
    parameter CNT_W = 4
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // User pins
    input wire sense_input_0,
    input wire sense_input_1,
    output reg enable_output_0,
    output reg enable_output_1,
    // Status to the rest of the device
    output reg run_mode,
    output reg irq
);

    // Qualifying time in cycles, rounded up, never below one
    localparam integer QUAL_RAW =
        (`USEP_SENSE_MIN_NS + `USEP_CLK_PERIOD_NS - 1) / `USEP_CLK_PERIOD_NS;
    localparam integer QUAL_INT = (QUAL_RAW < 1) ? 1 : QUAL_RAW;
    // The qualify compare adds one synced sample, so count one fewer;
    // synchroniser delay only shifts the window, it adds no held time
    localparam integer QUAL_CNT_INT = (QUAL_INT > 1) ? QUAL_INT - 1 : 1;
    localparam [3:0] QUAL_CNT = QUAL_CNT_INT[3:0];

    reg [1:0] sense_latch;
    reg [1:0] drive_bits;
    reg [`USEP_MODE_WIDTH-1:0] operating_mode_register;
    reg [1:0] int_status;
    reg [1:0] int_mask;
    reg [1:0] qual_prev;
    wire [1:0] qual;
    wire [1:0] pin_sync;
    wire [1:0] sense_pins;
    wire [1:0] qual_rise;
    wire [1:0] latch_clr;
    wire [1:0] int_clr;
    wire wr_en;
    wire rd_en;
    reg [31:0] next_prdata;
    reg next_pslverr;

    assign sense_pins = {sense_input_1, sense_input_0};

    ////////////////////////////////////////////////////////////////////////
    // Address decode for the error path; the read mux decodes with its own case
    function addr_mapped;
        input [11:0] a;
        begin
            addr_mapped = (a == `USEP_OFF_USER_IO) || (a == `USEP_OFF_MODE) ||
                          (a == `USEP_OFF_INT_STATUS) || (a == `USEP_OFF_INT_MASK) ||
                          (a == `USEP_OFF_PIN_LEVEL);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // one filter per sense input
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_sense
            usep_sense_filter #(
                .CNT_W(CNT_W),
                .QUAL_CYCLES(QUAL_CNT)
            ) u_filt (
                .pclk(pclk),
                .presetn(presetn),
                .pin_in(sense_pins[gi]),
                .pin_sync(pin_sync[gi]),
                .qualified(qual[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // APB strobes: zero wait state, access phase completes at once
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable && !pwrite;
    assign latch_clr = (wr_en && paddr == `USEP_OFF_USER_IO) ?
                       pwdata[`USEP_UIO_SENSE1:`USEP_UIO_SENSE0] : 2'h0;
    assign int_clr = (wr_en && paddr == `USEP_OFF_INT_STATUS) ? pwdata[1:0] : 2'h0;
    assign qual_rise = qual & ~qual_prev;

    ////////////////////////////////////////////////////////////////////////
    // sticky sense bits, set wins over clear
    // A level still qualified keeps the bit set through a clear in the same cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sense_latch <= 2'h0;
            qual_prev <= 2'h0;
        end
        else
        begin
            qual_prev <= qual;
            sense_latch <= (sense_latch & ~latch_clr) | qual;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: new qualified assertions, write one to clear
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_status <= 2'h0;
        else
            int_status <= (int_status & ~int_clr) | qual_rise | (qual & latch_clr);
    end

    ////////////////////////////////////////////////////////////////////////
    // writable registers, reset to cleared and stop mode
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drive_bits <= 2'h0;
            operating_mode_register <= `USEP_RST_MODE;
            int_mask <= `USEP_RST_MASK;
        end
        else if (wr_en)
        begin
            case (paddr)
                `USEP_OFF_USER_IO:
                    drive_bits <= pwdata[`USEP_UIO_DRIVE1:`USEP_UIO_DRIVE0];
                `USEP_OFF_MODE:
                    operating_mode_register <= pwdata[`USEP_MODE_WIDTH-1:0];
                `USEP_OFF_INT_MASK:
                    int_mask <= pwdata[1:0];
                default:
                    int_mask <= int_mask;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered pin drive and status outputs
    // Outputs lag the register by one cycle so every output is a flop
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_output_0 <= 1'b0;
            enable_output_1 <= 1'b0;
            run_mode <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            enable_output_0 <= drive_bits[0];
            enable_output_1 <= drive_bits[1];
            run_mode <= operating_mode_register[`USEP_MODE_RUN];
            irq <= |(int_status & int_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux, evaluated in the setup cycle
    always @*
    begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (paddr)
            `USEP_OFF_USER_IO:
                next_prdata = {28'h0000000, drive_bits, sense_latch};
            `USEP_OFF_MODE:
                next_prdata = {24'h000000, operating_mode_register};
            `USEP_OFF_INT_STATUS:
                next_prdata = {30'h00000000, int_status};
            `USEP_OFF_INT_MASK:
                next_prdata = {30'h00000000, int_mask};
            `USEP_OFF_PIN_LEVEL:
                next_prdata = {30'h00000000, pin_sync};
            default:
                next_prdata = 32'h0000_0000;
        endcase
        if (!addr_mapped(paddr))
            next_pslverr = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: ready in every access phase, data captured at setup
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            if (psel && !penable)
                pslverr <= next_pslverr;
            else
                pslverr <= 1'b0;
            if (rd_en)
                prdata <= next_prdata;
        end
    end

endmodule // usep_top

`default_nettype wire

//--- design/usep_regs.vh
// Register offsets, field positions, reset values and timing counts for the user sense/enable block
`ifndef USEP_REGS_VH
`define USEP_REGS_VH

// Register byte offsets
`define USEP_OFF_USER_IO 12'h000
`define USEP_OFF_MODE 12'h004
`define USEP_OFF_INT_STATUS 12'h008
`define USEP_OFF_INT_MASK 12'h00C
`define USEP_OFF_PIN_LEVEL 12'h010

// User I/O register fields
`define USEP_UIO_SENSE0 0
`define USEP_UIO_SENSE1 1
`define USEP_UIO_DRIVE0 2
`define USEP_UIO_DRIVE1 3

// Operating mode register fields
`define USEP_MODE_RUN 0
`define USEP_MODE_WIDTH 8

// Reset values
`define USEP_RST_USER_IO 4'h0
`define USEP_RST_MODE 8'h00
`define USEP_RST_MASK 2'h0

// Qualifying assertion time and clock rate
`define USEP_SENSE_MIN_NS 160
`define USEP_CLK_MHZ 25
`define USEP_CLK_PERIOD_NS 40

`endif

//--- design/usep_sense_filter.v
// One sense input: two-flop synchroniser and assertion-length qualifier
`timescale 1ns/1ps
`default_nettype none
`include "usep_regs.vh"

module usep_sense_filter #(
    parameter CNT_W = 4,
    parameter [3:0] QUAL_CYCLES = 4'h4
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Pin and qualified event
    input wire pin_in,
    output reg pin_sync,
    output reg qualified
);

    reg pin_meta;
    reg [CNT_W-1:0] held_count;

    ////////////////////////////////////////////////////////////////////////
    // Synchroniser; only the second flop is read by logic
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end
        else
        begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cycle count filter
    // Count stops at the threshold, so a long assertion gives one steady level
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            held_count <= {CNT_W{1'b0}};
            qualified <= 1'b0;
        end
        else if (!pin_sync)
        begin
            held_count <= {CNT_W{1'b0}};
            qualified <= 1'b0;
        end
        else
        begin
            if (held_count != QUAL_CYCLES)
                held_count <= held_count + {{(CNT_W-1){1'b0}}, 1'b1};
            qualified <= (held_count == QUAL_CYCLES);
        end
    end

endmodule // usep_sense_filter

`default_nettype wire

//--- verif/usep_pins_model.sv
// Far-side user logic that drives timed pulses on the sense pins
`timescale 1ns/1ps
`default_nettype none
module usep_pins_model (
    // Clock, reset and pulse request
    input wire logic pclk, presetn, start, hold,
    input wire logic [1:0] sel,
    input wire logic [7:0] len,
    // Sense pins
    output logic sense_input_0, sense_input_1
);
    logic [7:0] cnt;
    // hold keeps the pin up across a clear
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            cnt <= 8'h00;
            {sense_input_1, sense_input_0} <= 2'h0;
        end
        else if (start)
        begin
            cnt <= len;
            {sense_input_1, sense_input_0} <= sel;
        end
        else if (cnt > 8'h01)
            cnt <= cnt - 8'h01;
        else if (!hold)
            {sense_input_1, sense_input_0} <= 2'h0;
endmodule // usep_pins_model
`default_nettype wire

//--- verif/usep_top_props.sv
// Port-level checker of the user pin block
`timescale 1ns/1ps
`default_nettype none
module usep_top_props #(parameter CNT_W = 4) (
    // Clock and reset
    input wire logic pclk, presetn,
    // APB and pins
    input wire logic psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic sense_input_0, sense_input_1, enable_output_0, enable_output_1, run_mode, irq
);
    wire wr_uio = psel && penable && pready && pwrite && paddr == 12'h000;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_pready_next: assert property (psel && !penable |=> pready) else $error("late pready");
    chk_drive_bit0: assert property (
        wr_uio |=> ##1 enable_output_0 == $past(pwdata[2], 2)) else $error("drive 0 wrong");
    chk_drive_bit1: assert property (
        wr_uio |=> ##1 enable_output_1 == $past(pwdata[3], 2)) else $error("drive 1 wrong");
    chk_drive_hold: assert property (
        !$past(wr_uio) |=> $stable({enable_output_0, enable_output_1})) else $error("drive moved");
    chk_mode_write: assert property (
        psel && penable && pready && pwrite && paddr == 12'h004 |=> ##1 run_mode == $past(pwdata[0], 2))
        else $error("mode wrong");
    chk_reset_clear: assert property (
        $rose(presetn) |-> !run_mode && !irq && !enable_output_0 && !enable_output_1) else $error("not cleared");
    chk_unmapped_err: assert property (
        pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010}))
        else $error("bad pslverr");
    chk_irq_sticky: assert property (
        irq && !(psel && pwrite) && !$past(psel && pwrite) |=> irq) else $error("irq dropped");
endmodule // usep_top_props
bind usep_top usep_top_props #(.CNT_W(CNT_W)) i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .sense_input_0(sense_input_0), .sense_input_1(sense_input_1), .irq(irq),
    .enable_output_0(enable_output_0), .enable_output_1(enable_output_1), .run_mode(run_mode));
`default_nettype wire

//--- verif/user_sense_enable_pins_tb_top.sv
// Testbench: APB register tests of the user sense and enable pins
`timescale 1ns/1ps
`default_nettype none
module user_sense_enable_pins_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, start = 0, hold = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, s0, s1, en0, en1, run_mode, irq;
    logic [1:0] sel = 0;
    logic [7:0] len = 0;
    int err_total = 0, comparisons = 0, cyc = 0;
    always #20 pclk = ~pclk;
    usep_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sense_input_0(s0), .sense_input_1(s1), .enable_output_0(en0), .enable_output_1(en1),
        .run_mode(run_mode), .irq(irq));
    usep_pins_model i_pins (.pclk(pclk), .presetn(presetn), .start(start), .hold(hold), .sel(sel),
        .len(len), .sense_input_0(s0), .sense_input_1(s1));
    task complete_run;
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready, only the hang guard ends a wait
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd, exp);
    endtask
    task pulse(input logic [1:0] s, input logic [7:0] l);
        {sel, len, start} <= {s, l, 1'b1};
        @(posedge pclk);
        start <= 0;
        repeat (l + 10) @(posedge pclk);
    endtask
    task rst;
        presetn <= 0;
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
    endtask
    initial
    begin
        rst();
        rdc(12'h004, 0);
        rdc(12'h00C, 0);
        for (int v = 0; v < 4; v++)
        begin
            apb(1, 12'h000, v << 2);
            @(posedge pclk);
            chk({en1, en0}, v);
            rdc(12'h000, v << 2);
        end
        apb(1, 12'h004, 1);
        @(posedge pclk);
        chk(run_mode, 1);
        rst();
        chk({irq, run_mode, en1, en0}, 0);
        pulse(2'b01, 2);
        rdc(12'h000, 0);
        pulse(2'b01, 3);
        rdc(12'h000, 0);
        pulse(2'b01, 4);
        rdc(12'h000, 1);
        apb(1, 12'h000, 3);
        apb(1, 12'h008, 3);
        rdc(12'h000, 0);
        apb(1, 12'h00C, 3);
        for (int i = 0; i < 2; i++)
        begin
            pulse(2'(i + 1), 6);
            rdc(12'h000, i + 1);
            rdc(12'h008, i + 1);
            chk(irq, 1);
            repeat (20) @(posedge pclk);
            rdc(12'h000, i + 1);
            apb(1, 12'h000, 3);
            apb(1, 12'h008, 3);
            rdc(12'h000, 0);
            chk(irq, 0);
        end
        hold <= 1;
        pulse(2'b10, 6);
        rdc(12'h010, 2);
        apb(1, 12'h000, 3);
        rdc(12'h000, 2);
        hold <= 0;
        repeat (10) @(posedge pclk);
        apb(1, 12'h000, 3);
        rdc(12'h000, 0);
        apb(1, 12'h00C, 0);
        apb(1, 12'h008, 3);
        pulse(2'b01, 6);
        rdc(12'h008, 1);
        chk(irq, 0);
        apb(1, 12'h00C, 3);
        @(posedge pclk);
        chk(irq, 1);
        rdc(12'h100, 0);
        chk(er, 1);
        apb(1, 12'h100, 32'hF);
        chk(er, 1);
        rdc(12'h000, 1);
        complete_run();
    end
    // Hang guard, far above the expected run length
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            complete_run();
        end
    end
endmodule // user_sense_enable_pins_tb_top
`default_nettype wire
